/* File: arp_params.svh */
`ifndef ARP_PARAMS_SVH
`define ARP_PARAMS_SVH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define ARP_OFS_LOW_THR   16'h20A8
`define ARP_OFS_LOW_HYS   16'h20AC
`define ARP_OFS_HIGH_THR  16'h20B0
`define ARP_OFS_HIGH_HYS  16'h20B4
`define ARP_OFS_STEP      16'h20B8
`define ARP_OFS_GAIN      16'h2238
`define ARP_OFS_STATE     16'h2300
`define ARP_OFS_FLAGS1    16'h2304
`define ARP_OFS_FLAGS2    16'h2308
`define ARP_OFS_MASK      16'h230C
`define ARP_OFS_RESULT    16'h2310

// ****************************************************************
// Reset values and field layout
// ****************************************************************
`define ARP_RST_LIMIT     16'h0000
`define ARP_RST_GAIN      15'h4000
`define ARP_RST_MASK      3'h0
`define ARP_GAIN_FRAC     14
`define ARP_EVT_LOW       0
`define ARP_EVT_HIGH      1
`define ARP_EVT_STEP      2

`endif

/* File: arp_pkg.sv */
package arp_pkg;

   // ****************************************************************
   // Whole block state
   // ****************************************************************
   typedef struct packed {
      logic [15:0] low_thr;
      logic [15:0] low_hys;
      logic [15:0] high_thr;
      logic [15:0] high_hys;
      logic [15:0] step_lim;
      logic [14:0] gain;
      logic [2:0] mask;
      logic [2:0] flags1;
      logic [2:0] flags2;
      logic low_act;
      logic high_act;
      logic [15:0] prev;
      logic prev_vld;
      logic [15:0] res;
      logic res_vld;
      logic [31:0] prdata;
      logic pslverr;
   } arp_state_t;

endpackage : arp_pkg

/* File: arp_top.sv */
// Operation
// - Gain factor 15 bits, resets to unity
// - Gain applied to temperature channel only
// - Code 0x2000 halves, 0x7FFF nearly doubles
// - Zero gain gives zero result
// - Result below low limit sets low flags
// - Low flag held until above limit plus hysteresis
// - Result above high limit sets high flags
// - High flag held until below limit minus hysteresis
// - Limit registers 16 bits, reset zero
// - Gain register upper bits read zero
// - Checks configurable, limit, gain and mask registers read-write
// - Large step between results sets step flags
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`include "arp_params.svh"

module arp_top
   import arp_pkg::*;
#(
   parameter int DATA_W = 16,
   parameter int GAIN_W = 15
)
(
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [15:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic res_valid_i,
   input wire logic [15:0] res_data_i,
   input wire logic res_temp_i,
   output logic corr_valid_o,
   output logic [15:0] corr_data_o,
   output logic irq_o
);

   // ****************************************************************
   // Elaboration check
   // ****************************************************************
   // Field layout is fixed by the register map
   if (DATA_W != 16 || GAIN_W != 15)
   begin : g_bad_width
      $error("arp_top supports only DATA_W 16 and GAIN_W 15");
   end

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Unsigned Q1.14 scaling, saturates at full scale
   function automatic logic [15:0] fn_gain(input logic [15:0] d,
                                           input logic [14:0] g);
      logic [30:0] prod;
      logic [16:0] scaled;
      prod = 31'(d) * 31'(g);
      scaled = prod[30:`ARP_GAIN_FRAC];
      if (scaled[16])
         return 16'hFFFF;
      else
         return scaled[15:0];
   endfunction : fn_gain

   function automatic logic [15:0] fn_absdiff(input logic [15:0] a,
                                              input logic [15:0] b);
      if (a >= b)
         return 16'(a - b);
      else
         return 16'(b - a);
   endfunction : fn_absdiff

   // ****************************************************************
   // Register state
   // ****************************************************************
   arp_state_t q;
   arp_state_t d;
   logic [15:0] corr_w;
   logic [16:0] low_clr_w;
   logic [16:0] high_clr_w;
   logic [2:0] evt_w;
   logic setup_w;
   logic acc_w;
   logic wr_w;
   logic rd_w;

   // ****************************************************************
   // Bus and result path
   // ****************************************************************
   always_comb
   begin
      d = q;
      setup_w = psel_i && !penable_i;
      acc_w = psel_i && penable_i;
      wr_w = acc_w && pwrite_i;
      rd_w = acc_w && !pwrite_i;
      evt_w = 3'h0;
      // Only the temperature channel is scaled
      if (res_temp_i)
         corr_w = fn_gain(res_data_i, q.gain);
      else
         corr_w = res_data_i;
      // Wide sums so the release points never wrap
      low_clr_w = {1'b0, q.low_thr} + {1'b0, q.low_hys};
      high_clr_w = {1'b0, q.high_thr} - {1'b0, q.high_hys};
      d.res_vld = res_valid_i;
      if (res_valid_i)
      begin
         d.res = corr_w;
         // Low window with hysteresis
         if (corr_w < q.low_thr)
            d.low_act = 1'b1;
         else if ({1'b0, corr_w} > low_clr_w)
            d.low_act = 1'b0;
         // High window; negative release never clears
         if (corr_w > q.high_thr)
            d.high_act = 1'b1;
         else if (!high_clr_w[16] && {1'b0, corr_w} < high_clr_w)
            d.high_act = 1'b0;
         evt_w[`ARP_EVT_LOW] = d.low_act;
         evt_w[`ARP_EVT_HIGH] = d.high_act;
         // First result after reset has no predecessor
         if (q.prev_vld && fn_absdiff(corr_w, q.prev) > q.step_lim)
            evt_w[`ARP_EVT_STEP] = 1'b1;
         d.prev = corr_w;
         d.prev_vld = 1'b1;
      end
      // Read data latched at setup, so it is stable in access
      if (setup_w)
      begin
         d.prdata = 32'h0000_0000;
         d.pslverr = 1'b0;
         case (paddr_i)
            `ARP_OFS_LOW_THR: d.prdata[15:0] = q.low_thr;
            `ARP_OFS_LOW_HYS: d.prdata[15:0] = q.low_hys;
            `ARP_OFS_HIGH_THR: d.prdata[15:0] = q.high_thr;
            `ARP_OFS_HIGH_HYS: d.prdata[15:0] = q.high_hys;
            `ARP_OFS_STEP: d.prdata[15:0] = q.step_lim;
            `ARP_OFS_GAIN: d.prdata[14:0] = q.gain;
            `ARP_OFS_STATE: d.prdata[1:0] = {q.high_act, q.low_act};
            `ARP_OFS_FLAGS1: d.prdata[2:0] = q.flags1;
            `ARP_OFS_FLAGS2: d.prdata[2:0] = q.flags2;
            `ARP_OFS_MASK: d.prdata[2:0] = q.mask;
            `ARP_OFS_RESULT: d.prdata[15:0] = q.res;
            default: d.pslverr = 1'b1;
         endcase
      end
      if (wr_w)
      begin
         case (paddr_i)
            `ARP_OFS_LOW_THR: d.low_thr = pwdata_i[15:0];
            `ARP_OFS_LOW_HYS: d.low_hys = pwdata_i[15:0];
            `ARP_OFS_HIGH_THR: d.high_thr = pwdata_i[15:0];
            `ARP_OFS_HIGH_HYS: d.high_hys = pwdata_i[15:0];
            `ARP_OFS_STEP: d.step_lim = pwdata_i[15:0];
            `ARP_OFS_GAIN: d.gain = pwdata_i[14:0];
            `ARP_OFS_MASK: d.mask = pwdata_i[2:0];
            default: d.mask = q.mask;
         endcase
      end
      // Clear only bits shown at setup, so no late event is lost
      if (rd_w && paddr_i == `ARP_OFS_FLAGS1)
         d.flags1 = d.flags1 & ~q.prdata[2:0];
      if (rd_w && paddr_i == `ARP_OFS_FLAGS2)
         d.flags2 = d.flags2 & ~q.prdata[2:0];
      d.flags1 = d.flags1 | evt_w;
      d.flags2 = d.flags2 | evt_w;
   end

   // ****************************************************************
   // Register update
   // ****************************************************************
   always_ff @(posedge core_clk_i)
   begin
      if (!rst_b_i)
      begin
         q <= '0;
         q.low_thr <= `ARP_RST_LIMIT;
         q.low_hys <= `ARP_RST_LIMIT;
         q.high_thr <= `ARP_RST_LIMIT;
         q.high_hys <= `ARP_RST_LIMIT;
         q.step_lim <= `ARP_RST_LIMIT;
         q.gain <= `ARP_RST_GAIN;
         q.mask <= `ARP_RST_MASK;
      end
      else
      begin
         q <= d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign pready_o = psel_i && penable_i;
   assign prdata_o = q.prdata;
   assign pslverr_o = q.pslverr && pready_o;
   assign corr_valid_o = q.res_vld;
   assign corr_data_o = q.res;
   assign irq_o = |((q.flags1 | q.flags2) & q.mask);

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);

   AST_GAIN_RESET: assert property (
      !$past(rst_b_i) |-> q.gain == `ARP_RST_GAIN)
      else $error("Gain not unity after reset");

   AST_OTHER_CHAN: assert property (
      res_valid_i && !res_temp_i |=> corr_data_o == $past(res_data_i)
      && corr_valid_o)
      else $error("Non temperature result altered");

   AST_HALF_GAIN: assert property (
      res_valid_i && res_temp_i && q.gain == 15'h2000
      |=> corr_data_o == ($past(res_data_i) >> 1))
      else $error("Half gain code wrong");

   AST_ZERO_GAIN: assert property (
      res_valid_i && res_temp_i && q.gain == 15'h0000
      |=> corr_data_o == 16'h0000)
      else $error("Zero gain not zero");

   AST_LOW_SET: assert property (
      res_valid_i && corr_w < q.low_thr
      |=> q.flags1[`ARP_EVT_LOW] && q.flags2[`ARP_EVT_LOW] && q.low_act)
      else $error("Low event not flagged");

   AST_LOW_HOLD: assert property (
      q.low_act && !(res_valid_i && {1'b0, corr_w} > low_clr_w)
      |=> q.low_act)
      else $error("Low state released early");

   AST_HIGH_SET: assert property (
      res_valid_i && corr_w > q.high_thr
      |=> q.flags1[`ARP_EVT_HIGH] && q.flags2[`ARP_EVT_HIGH])
      else $error("High event not flagged");

   AST_HIGH_HOLD: assert property (
      q.high_act && !(res_valid_i && !high_clr_w[16]
      && {1'b0, corr_w} < high_clr_w) |=> q.high_act)
      else $error("High state released early");

   AST_STEP_SET: assert property (
      res_valid_i && q.prev_vld && fn_absdiff(corr_w, q.prev) > q.step_lim
      |=> q.flags1[`ARP_EVT_STEP] && q.flags2[`ARP_EVT_STEP])
      else $error("Step event not flagged");

   AST_GAIN_RSVD: assert property (
      setup_w && !pwrite_i && paddr_i == `ARP_OFS_GAIN
      |=> prdata_o[31:15] == 17'h00000 && prdata_o[14:0] == q.gain)
      else $error("Gain reserved bits not zero");

   AST_LIMIT_RSVD: assert property (
      setup_w && paddr_i == `ARP_OFS_LOW_THR |=> prdata_o[31:16] == 16'h0000)
      else $error("Limit reserved bits not zero");

   AST_TEMP_UNITY: assert property (
      res_valid_i && res_temp_i && q.gain == `ARP_RST_GAIN
      |=> corr_data_o == $past(res_data_i))
      else $error("Unity gain altered result");

   AST_LOW_CLR: assert property (
      res_valid_i && corr_w > q.low_thr
      && 16'(corr_w - q.low_thr) > q.low_hys |=> !q.low_act)
      else $error("Low state not released");

   AST_HIGH_CLR: assert property (
      res_valid_i && q.high_hys <= q.high_thr
      && corr_w < 16'(q.high_thr - q.high_hys) |=> !q.high_act)
      else $error("High state not released");

   AST_FLAG_STICKY: assert property (
      !res_valid_i && !(rd_w && paddr_i == `ARP_OFS_FLAGS1)
      |=> $stable(q.flags1))
      else $error("Flag changed without event or read");

   AST_RD_CLEAR: assert property (
      rd_w && paddr_i == `ARP_OFS_FLAGS2 && !res_valid_i
      |=> (q.flags2 & prdata_o[2:0]) == 3'h0)
      else $error("Read flags not cleared");

   AST_FIRST_STEP: assert property (
      res_valid_i && !q.prev_vld && !q.flags1[`ARP_EVT_STEP]
      |=> !q.flags1[`ARP_EVT_STEP])
      else $error("Step flagged on first result");

   AST_IRQ_OFF: assert property (
      q.mask == 3'h0 |-> !irq_o)
      else $error("Masked interrupt raised");

   AST_IRQ_ON: assert property (
      (q.flags1 & q.mask) != 3'h0 |-> irq_o)
      else $error("Unmasked flag gave no interrupt");

   AST_CORR_PULSE: assert property (
      !res_valid_i |=> !corr_valid_o)
      else $error("Result valid without new result");

   AST_CORR_HOLD: assert property (
      !res_valid_i |=> $stable(corr_data_o))
      else $error("Result changed without new result");

   AST_RO_WRITE: assert property (
      wr_w && paddr_i == `ARP_OFS_RESULT && !res_valid_i
      |=> $stable(q.res))
      else $error("Read only result written");

   AST_GAIN_WRITE: assert property (
      wr_w && paddr_i == `ARP_OFS_GAIN
      |=> {17'h00000, q.gain} == ($past(pwdata_i) & 32'h0000_7FFF))
      else $error("Gain write not taken");

   AST_STEP_WRITE: assert property (
      wr_w && paddr_i == `ARP_OFS_STEP
      |=> {16'h0000, q.step_lim} == ($past(pwdata_i) & 32'h0000_FFFF))
      else $error("Step limit write not taken");

   AST_HYS_WRITE: assert property (
      wr_w && paddr_i == `ARP_OFS_LOW_HYS
      |=> {16'h0000, q.low_hys} == ($past(pwdata_i) & 32'h0000_FFFF))
      else $error("Hysteresis write not taken");

   AST_MASK_WRITE: assert property (
      wr_w && paddr_i == `ARP_OFS_MASK
      |=> {29'h0000_0000, q.mask} == ($past(pwdata_i) & 32'h0000_0007))
      else $error("Mask write not taken");

   AST_FLAGS_RSVD: assert property (
      setup_w && paddr_i == `ARP_OFS_FLAGS1
      |=> prdata_o[31:3] == 29'h0000_0000)
      else $error("Flag reserved bits not zero");

   // ****************************************************************
   // Coverage
   // ****************************************************************
   COV_TEMP_SCALED: cover property (
      res_valid_i && res_temp_i && q.gain != `ARP_RST_GAIN);
   COV_LOW_CYCLE: cover property (q.low_act ##[1:50] !q.low_act);
   COV_STEP_IRQ: cover property (q.flags1[`ARP_EVT_STEP] && irq_o);
   COV_UNMAPPED: cover property (pslverr_o);
   COV_CLEAR_RACE: cover property (rd_w && res_valid_i);

endmodule : arp_top

/* File: arp_res_src.sv */
`timescale 1ns/1ps
// ****************************************************************
// Converter result source
// ****************************************************************
module arp_res_src
(
   input wire logic core_clk_i,
   output logic res_valid_o,
   output logic [15:0] res_data_o,
   output logic res_temp_o
);
   initial
   begin
      res_valid_o = 1'b0;
      res_data_o = 16'h0000;
      res_temp_o = 1'b0;
   end
   // One pulse per new result; stale data inverted so it is never reused
   task send(input logic [15:0] d, input logic t);
   begin
      @(posedge core_clk_i);
      res_valid_o <= 1'b1;
      res_data_o <= d;
      res_temp_o <= t;
      @(posedge core_clk_i);
      res_valid_o <= 1'b0;
      res_data_o <= ~d;
      res_temp_o <= ~t;
   end
   endtask : send
endmodule : arp_res_src

/* File: testbench.sv */
`timescale 1ns/1ps
`include "arp_params.svh"
module testbench;
   logic core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic res_valid, res_temp, corr_valid, irq;
   logic [15:0] paddr, res_data, corr_data;
   logic [31:0] pwdata, prdata, rd;
   int errors, check_count, i;
   arp_top u_dut (.core_clk_i(core_clk), .rst_b_i(rst_b), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .res_valid_i(res_valid), .res_data_i(res_data),
      .res_temp_i(res_temp), .corr_valid_o(corr_valid),
      .corr_data_o(corr_data), .irq_o(irq));
   arp_res_src u_src (.core_clk_i(core_clk), .res_valid_o(res_valid),
      .res_data_o(res_data), .res_temp_o(res_temp));
   always #12.5 core_clk = ~core_clk;
   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task report_and_stop;
   begin
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask : report_and_stop
   task check(input string nm, input logic [31:0] e, input logic [31:0] g);
   begin
      check_count++;
      if (g !== e)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   end
   endtask : check
   // Holds the request until pready is seen high at an edge
   task apb(input logic w, input logic [15:0] a, input logic [31:0] wd);
      int n;
   begin
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      check("pslverr", (a == 16'h2400), pslverr);
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         errors++;
         report_and_stop();
      end
   end
   endtask : apb
   task rdchk(input string nm, input logic [15:0] a, input logic [31:0] e);
   begin
      apb(1'b0, a, 32'h0000_0000);
      check(nm, e, rd);
   end
   endtask : rdchk
   task res(input logic [15:0] d, input logic t, input logic [15:0] e);
   begin
      u_src.send(d, t);
      #1;
      check("corr_valid", 32'h1, {31'h0, corr_valid});
      check("corr_data", {16'h0, e}, {16'h0, corr_data});
      @(posedge core_clk);
      #1;
      check("corr_valid", 32'h0, {31'h0, corr_valid});
   end
   endtask : res
   // Both flag registers see the same event; each clears on its own read
   task flags(input logic [2:0] e, input logic q);
   begin
      check("irq", {31'h0, q}, {31'h0, irq});
      rdchk("flags1", `ARP_OFS_FLAGS1, {29'h0, e});
      rdchk("flags2", `ARP_OFS_FLAGS2, {29'h0, e});
   end
   endtask : flags
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task regs;
   begin
      rdchk("gain", `ARP_OFS_GAIN, 32'h0000_4000);
      rdchk("unmapped", 16'h2400, 32'h0000_0000);
      apb(1'b1, `ARP_OFS_RESULT, 32'hFFFF_FFFF);
      rdchk("result", `ARP_OFS_RESULT, 32'h0000_0000);
      for (i = 0; i < 5; i++)
      begin
         rdchk("limit", `ARP_OFS_LOW_THR + 16'(4 * i), 32'h0);
         apb(1'b1, `ARP_OFS_LOW_THR + 16'(4 * i), 32'hFFFF_FFFF);
         rdchk("limit", `ARP_OFS_LOW_THR + 16'(4 * i), 32'hFFFF);
      end
      apb(1'b1, `ARP_OFS_GAIN, 32'hFFFF_FFFF);
      rdchk("gain", `ARP_OFS_GAIN, 32'h0000_7FFF);
   end
   endtask : regs
   task gains;
   begin
      apb(1'b1, `ARP_OFS_GAIN, 32'h2000);
      res(16'h1000, 1'b1, 16'h0800);
      res(16'h1000, 1'b0, 16'h1000);
      apb(1'b1, `ARP_OFS_GAIN, 32'h7FFF);
      res(16'h1000, 1'b1, 16'h1FFF);
      apb(1'b1, `ARP_OFS_GAIN, 32'h0);
      res(16'h1234, 1'b1, 16'h0000);
      apb(1'b1, `ARP_OFS_GAIN, 32'h4000);
      res(16'hABCD, 1'b1, 16'hABCD);
   end
   endtask : gains
   task limits;
   begin
      apb(1'b1, `ARP_OFS_MASK, 32'h7);
      apb(1'b1, `ARP_OFS_LOW_THR, 32'd100);
      apb(1'b1, `ARP_OFS_LOW_HYS, 32'd50);
      res(16'd90, 1'b0, 16'd90);
      flags(3'h1, 1'b1);
      res(16'd150, 1'b0, 16'd150);
      flags(3'h1, 1'b1);
      res(16'd151, 1'b0, 16'd151);
      flags(3'h0, 1'b0);
      apb(1'b1, `ARP_OFS_MASK, 32'h6);
      res(16'd90, 1'b0, 16'd90);
      flags(3'h1, 1'b0);
      apb(1'b1, `ARP_OFS_MASK, 32'h7);
      apb(1'b1, `ARP_OFS_LOW_THR, 32'd0);
      apb(1'b1, `ARP_OFS_HIGH_THR, 32'd1000);
      apb(1'b1, `ARP_OFS_HIGH_HYS, 32'd100);
      res(16'd500, 1'b0, 16'd500);
      apb(1'b0, `ARP_OFS_FLAGS1, 32'h0);
      apb(1'b0, `ARP_OFS_FLAGS2, 32'h0);
      res(16'd1001, 1'b0, 16'd1001);
      flags(3'h2, 1'b1);
      rdchk("state", `ARP_OFS_STATE, 32'h0000_0002);
      rdchk("result", `ARP_OFS_RESULT, 32'h0000_03E9);
      res(16'd900, 1'b0, 16'd900);
      flags(3'h2, 1'b1);
      res(16'd899, 1'b0, 16'd899);
      flags(3'h0, 1'b0);
   end
   endtask : limits
   task steps;
   begin
      apb(1'b1, `ARP_OFS_STEP, 32'd10);
      res(16'd511, 1'b0, 16'd511);
      flags(3'h4, 1'b1);
      res(16'd521, 1'b0, 16'd521);
      flags(3'h0, 1'b0);
   end
   endtask : steps
   // Events on the setup and access edges of a flag read must survive
   task race;
   begin
      res(16'h03E9, 1'b0, 16'h03E9);
      fork
         apb(1'b0, `ARP_OFS_FLAGS1, 32'h0000_0000);
         begin
            @(posedge core_clk);
            u_src.send(16'h03EA, 1'b0);
         end
      join
      check("flags1", 32'h0000_0006, rd);
      rdchk("flags1", `ARP_OFS_FLAGS1, 32'h0000_0002);
      fork
         apb(1'b0, `ARP_OFS_FLAGS1, 32'h0000_0000);
         u_src.send(16'h03EB, 1'b0);
      join
      check("flags1", 32'h0000_0000, rd);
      rdchk("flags1", `ARP_OFS_FLAGS1, 32'h0000_0002);
   end
   endtask : race
   initial
   begin
      core_clk = 1'b0;
      rst_b = 1'b0;
      {psel, penable, pwrite} = 3'h0;
      paddr = 16'h0000;
      pwdata = 32'h0000_0000;
      errors = 0;
      check_count = 0;
      repeat (5) @(posedge core_clk);
      rst_b <= 1'b1;
      regs();
      gains();
      limits();
      steps();
      race();
      report_and_stop();
   end
endmodule : testbench
